// >>> hw/ism_idle_sleep_ctrl.sv
`timescale 1ns/1ps
`include "ism_regs.svh"
module ism_idle_sleep_ctrl
   import ism_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // software control
   input  wire logic       idle_select_wr,
   input  wire logic       idle_select_wdata,
   output      logic       idle_select,
   input  wire logic       recover_on_irq,
   input  wire logic       doze_en,
   input  wire logic       doze_set,
   input  wire logic       clock_out_enable_n,
   // core events
   input  wire logic       sleep_exec,
   input  wire logic       irq_event,
   input  wire logic       global_irq_enable,
   input  wire logic       windowed_watchdog,
   // status and gating
   output      ism_mode_t  mode,
   output      ism_gate_t  gate,
   output      logic       doze_active,
   output      logic       wdt_reset_req,
   output      logic       wdt_wake
);

   ism_state_t st_reg;
   ism_state_t st_next;
   logic       wake_irq;
   logic       wake_wdt;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      st_next          = st_reg;
      st_next.wdt_wake = 1'h0;
      // global enable only decides vectoring, not wake
      wake_irq = irq_event;
      wake_wdt = windowed_watchdog && (st_reg.mode == ISM_IDLE);
      if (idle_select_wr) begin
         st_next.idle_select = idle_select_wdata;
      end
      if (doze_set && doze_en) begin
         st_next.doze_active = 1'h1;
      end
      if (!doze_en) begin
         st_next.doze_active = 1'h0;
      end
      unique case (st_reg.mode)
         ISM_RUN: begin
            if (sleep_exec) begin
               // a write in the same cycle as sleep wins
               if (st_next.idle_select == `ISM_SEL_IDLE) begin
                  st_next.mode = ISM_IDLE;
               end else begin
                  st_next.mode = ISM_SLEEP;
               end
            end
         end
         ISM_IDLE: begin
            if (wake_irq || wake_wdt) begin
               st_next.mode = ISM_RUN;
               if (wake_irq && recover_on_irq == `ISM_ROI_ON && doze_en) begin
                  st_next.doze_active = 1'h0;
               end
               // watchdog alone never touches doze
               st_next.wdt_wake = wake_wdt && !wake_irq;
            end
         end
         ISM_SLEEP: begin
            if (wake_irq) begin
               st_next.mode = ISM_RUN;
               if (recover_on_irq == `ISM_ROI_ON && doze_en) begin
                  st_next.doze_active = 1'h0;
               end
            end
         end
         default: begin
            st_next.mode = ISM_RUN;
         end
      endcase
      // gating follows the mode being entered
      st_next.gate.cpu_run          = (st_next.mode == ISM_RUN);
      st_next.gate.pmem_on          = (st_next.mode == ISM_RUN);
      st_next.gate.sysosc_periph_en = (st_next.mode != ISM_SLEEP);
      st_next.gate.intosc_periph_en = 1'h1;
      st_next.gate.clkout_run       = (clock_out_enable_n == `ISM_CLKOUT_ON) &&
                                      (st_next.mode != ISM_SLEEP);
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg.mode        <= ISM_RUN;
         st_reg.idle_select <= `ISM_SEL_RST;
         st_reg.doze_active <= 1'h0;
         st_reg.wdt_wake    <= 1'h0;
         st_reg.gate        <= '{cpu_run: 1'h1, pmem_on: 1'h1, sysosc_periph_en: 1'h1,
                                 intosc_periph_en: 1'h1, clkout_run: 1'h0};
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign idle_select   = st_reg.idle_select;
   assign mode          = st_reg.mode;
   assign gate          = st_reg.gate;
   assign doze_active   = st_reg.doze_active;
   assign wdt_wake      = st_reg.wdt_wake;
   // timeout resets only outside idle
   assign wdt_reset_req = windowed_watchdog && (st_reg.mode != ISM_IDLE);
endmodule

// >>> hw/ism_regs.svh
`ifndef ISM_REGS_SVH
`define ISM_REGS_SVH
// idle-select value that picks full sleep
`define ISM_SEL_SLEEP 1'h0
// idle-select value that picks idle
`define ISM_SEL_IDLE 1'h1
// clock-out enable is active low
`define ISM_CLKOUT_ON 1'h0
`define ISM_ROI_ON 1'h1
// reset value of the idle-select control
`define ISM_SEL_RST 1'h0
`endif

// >>> hw/ism_pkg.sv
package ism_pkg;
   typedef enum logic [2:0] {
      ISM_RUN   = 3'h1,
      ISM_IDLE  = 3'h2,
      ISM_SLEEP = 3'h4
   } ism_mode_t;

   typedef struct packed {
      logic cpu_run;
      logic pmem_on;
      logic sysosc_periph_en;
      logic intosc_periph_en;
      logic clkout_run;
   } ism_gate_t;

   typedef struct packed {
      ism_mode_t mode;
      logic      idle_select;
      logic      doze_active;
      logic      wdt_wake;
      ism_gate_t gate;
   } ism_state_t;
endpackage

// >>> bench/ism_idle_sleep_ctrl_chk.sv
`timescale 1ns/1ps
module ism_idle_sleep_ctrl_chk
   import ism_pkg::*;
(
   input wire logic clk, rst, idle_select_wr, idle_select, sleep_exec, irq_event, windowed_watchdog,
   input wire logic recover_on_irq, doze_en, doze_set, doze_active, wdt_wake, wdt_reset_req, clock_out_enable_n,
   input wire ism_mode_t mode,
   input wire ism_gate_t gate
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_full_sleep: assert property (
      mode == ISM_RUN && sleep_exec && !idle_select && !idle_select_wr |=> mode == ISM_SLEEP) else $error("no sleep");
   a_idle_entry: assert property (
      mode == ISM_RUN && sleep_exec && idle_select && !idle_select_wr |=> mode == ISM_IDLE) else $error("no idle");
   a_idle_gating: assert property (
      mode == ISM_IDLE |-> !gate.cpu_run && !gate.pmem_on && gate.sysosc_periph_en) else $error("idle gate");
   a_sleep_gating: assert property (
      mode == ISM_SLEEP |-> !gate.sysosc_periph_en && gate.intosc_periph_en) else $error("sleep gate");
   a_clkout_idle: assert property (
      mode == ISM_IDLE && !clock_out_enable_n && $stable(clock_out_enable_n) |-> gate.clkout_run) else $error("clkout");
   a_irq_wake: assert property (
      mode == ISM_IDLE && irq_event && !idle_select_wr |=> mode == ISM_RUN && $stable(idle_select)) else $error("irq");
   a_roi_speed: assert property (
      mode == ISM_IDLE && irq_event && recover_on_irq && doze_en |=> !doze_active) else $error("roi");
   a_wdt_wake: assert property (
      mode == ISM_IDLE && windowed_watchdog && !irq_event && !doze_set && doze_en |-> !wdt_reset_req
      ##1 mode == ISM_RUN && wdt_wake && $stable(doze_active)) else $error("wdt");
endmodule
bind ism_idle_sleep_ctrl ism_idle_sleep_ctrl_chk i_ism_idle_sleep_ctrl_chk (.*);

// >>> bench/ism_idle_sleep_ctrl_tb.sv
`timescale 1ns/1ps
module ism_idle_sleep_ctrl_tb;
   import ism_pkg::*;
   logic clk = 0, rst = 1, idle_select_wr = 0, idle_select_wdata = 1, recover_on_irq = 0, doze_en = 0;
   logic doze_set = 0, clock_out_enable_n = 0, sleep_exec = 0, irq_event = 0, global_irq_enable = 0;
   logic windowed_watchdog = 0, idle_select, doze_active, wdt_reset_req, wdt_wake;
   ism_mode_t mode;
   ism_gate_t gate;
   int num_errors = 0, checks = 0;
   ism_idle_sleep_ctrl i_ism_idle_sleep_ctrl (.*);
   always #50 clk = ~clk;
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(string n, logic [7:0] s, e);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   // one-cycle request, released 10 ns after the edge that takes it
   task automatic pulse(ref logic s);
      s = 1;
      @(posedge clk) #10 s = 0;
   endtask
   task automatic t_sleep;
      pulse(sleep_exec);
      chk("mode", mode, ISM_SLEEP);
      chk("gate", gate, 5'h02);
      windowed_watchdog = 1;
      #1 chk("rstreq", wdt_reset_req, 1'h1);
      @(posedge clk) #10 windowed_watchdog = 0;
      chk("mode", mode, ISM_SLEEP);
      pulse(irq_event);
      chk("mode", mode, ISM_RUN);
   endtask
   task automatic t_idle;
      pulse(idle_select_wr);
      chk("sel", idle_select, 1'h1);
      repeat (2) begin
         pulse(sleep_exec);
         chk("mode", mode, ISM_IDLE);
         chk("gate", gate, 5'h07);
         pulse(irq_event);
         chk("wake", {mode, idle_select}, {ISM_RUN, 1'h1});
      end
      pulse(sleep_exec);
      windowed_watchdog = 1;
      #1 chk("rstreq", wdt_reset_req, 1'h0);
      @(posedge clk) #10 windowed_watchdog = 0;
      chk("wwake", {mode, wdt_wake}, {ISM_RUN, 1'h1});
   endtask
   task automatic t_doze;
      recover_on_irq = 1;
      doze_en = 1;
      pulse(doze_set);
      chk("doze", doze_active, 1'h1);
      pulse(sleep_exec);
      pulse(irq_event);
      chk("doze", doze_active, 1'h0);
      pulse(doze_set);
      pulse(sleep_exec);
      pulse(windowed_watchdog);
      chk("doze", doze_active, 1'h1);
      idle_select_wdata = 0;
      pulse(idle_select_wr);
      chk("sel", idle_select, 1'h0);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #10 rst = 0;
      t_sleep();
      t_idle();
      t_doze();
      tally_and_finish();
   end
   initial #9000 begin
      num_errors++;
      tally_and_finish();
   end
endmodule
